//--- hw/iac_top.sv
// input alarm, counter and usage meter for one digital input
// assumes DIN_I is the conditioned input state, asynchronous to MCLK_I
`default_nettype none
module iac_top #(
    parameter int MS_TICK_CYC = iac_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    // conditioned input
    input wire logic DIN_I,
    // register port
    input wire logic [iac_pkg::AW-1:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // requests and interrupt
    output iac_pkg::iac_req_t REQ_O,
    output logic IRQ_O
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [31:0] iac_scale(input logic [31:0] raw, input logic [15:0] s);
        logic [47:0] p;
        p = raw * s;
        if (s == 16'h0000) begin
            return raw;
        end
        return p[iac_pkg::SCALE_FRAC +: 32];
    endfunction : iac_scale

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic din_m_r, din_s_r, din_prev_r;
    iac_pkg::iac_ctrl_t ctrl_r;
    logic [iac_pkg::NAL-1:0] note_en_r, sts_r, mask_r;
    logic [iac_pkg::NAL-2:0] svc_en_r;
    logic [15:0] scale_r;
    logic [31:0] period_r, trig_a_r, trig_b_r, use_set_r;
    logic [31:0] delay_r [iac_pkg::NAL];
    logic [31:0] hold_cnt_r [iac_pkg::NAL];
    iac_pkg::iac_hold_t hold_st_r [iac_pkg::NAL];
    logic [31:0] acc_r, last_r, win_r, usage_r, tick_cnt_r;
    iac_pkg::iac_req_t req_r;
    logic [31:0] rdata_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic wr_ctrl = WR_I && (ADDR_I == iac_pkg::OFS_CTRL);
    wire logic wr_note = WR_I && (ADDR_I == iac_pkg::OFS_NOTE_EN);
    wire logic wr_svc = WR_I && (ADDR_I == iac_pkg::OFS_SVC_EN);
    wire logic wr_scale = WR_I && (ADDR_I == iac_pkg::OFS_SCALE);
    wire logic wr_period = WR_I && (ADDR_I == iac_pkg::OFS_PERIOD);
    wire logic wr_trig_a = WR_I && (ADDR_I == iac_pkg::OFS_TRIG_A);
    wire logic wr_trig_b = WR_I && (ADDR_I == iac_pkg::OFS_TRIG_B);
    wire logic wr_use_set = WR_I && (ADDR_I == iac_pkg::OFS_USE_SET);
    wire logic wr_sts = WR_I && (ADDR_I == iac_pkg::OFS_STATUS);
    wire logic wr_mask = WR_I && (ADDR_I == iac_pkg::OFS_MASK);
    wire logic wr_cmd = WR_I && (ADDR_I == iac_pkg::OFS_CMD);
    wire logic wr_delay = WR_I &&
        (ADDR_I[iac_pkg::AW-1:4] == iac_pkg::OFS_DELAY0[iac_pkg::AW-1:4]);
    wire logic [1:0] delay_idx = ADDR_I[3:2];
    wire logic clr_cnt = wr_cmd && WDATA_I[iac_pkg::CMD_CLR_CNT];
    wire logic clr_use = wr_cmd && WDATA_I[iac_pkg::CMD_CLR_USE];

    // ------------------------------------------------------------
    // time base and input
    // ------------------------------------------------------------
    wire logic tick = (tick_cnt_r == 32'(MS_TICK_CYC - 1));
    wire logic din_mon = din_s_r ^ ctrl_r.alarm_polarity_inv;
    wire logic edge_on = din_s_r && !din_prev_r;
    wire logic edge_off = !din_s_r && din_prev_r;
    wire logic cnt_inc = ctrl_r.count_edge_select ? edge_on : edge_off;
    wire logic metering = (din_s_r == ctrl_r.metered_state_select);

    // ------------------------------------------------------------
    // counter view
    // ------------------------------------------------------------
    wire logic per_mode = (period_r != 32'h0000_0000);
    wire logic win_end = per_mode && tick && (win_r + 32'h1 >= period_r);
    wire logic [31:0] acc_inc = acc_r + {31'h0, cnt_inc};
    wire logic [31:0] raw_view = per_mode ? last_r : acc_r;
    wire logic [31:0] count_view = iac_scale(raw_view, scale_r);

    // ------------------------------------------------------------
    // alarm conditions and firing
    // ------------------------------------------------------------
    logic [iac_pkg::NAL-1:0] cond, fire;
    assign cond[iac_pkg::AL_STATE] = ctrl_r.state_alarm_en && din_mon;
    assign cond[iac_pkg::AL_CNT_A] = ctrl_r.cnt_a_en && (count_view > trig_a_r);
    assign cond[iac_pkg::AL_CNT_B] = ctrl_r.cnt_b_en && (count_view > trig_b_r);
    assign cond[iac_pkg::AL_USAGE] = ctrl_r.usage_alarm_en &&
        (usage_r >= use_set_r);
    always_comb begin
        for (int i = 0; i < iac_pkg::NAL; i++) begin
            fire[i] = cond[i] && (hold_st_r[i] == iac_pkg::IAC_ARMED);
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            ctrl_r <= iac_pkg::CTRL_RST;
            note_en_r <= '0;
            svc_en_r <= '0;
            scale_r <= '0;
            period_r <= '0;
            trig_a_r <= '0;
            trig_b_r <= '0;
            use_set_r <= '0;
            mask_r <= '0;
            for (int i = 0; i < iac_pkg::NAL; i++) begin
                delay_r[i] <= iac_pkg::REARM_DELAY_MS_DEF;
            end
        end else begin
            if (wr_ctrl) ctrl_r <= WDATA_I[6:0];
            if (wr_note) note_en_r <= WDATA_I[iac_pkg::NAL-1:0];
            if (wr_svc) svc_en_r <= WDATA_I[iac_pkg::NAL-2:0];
            if (wr_scale) scale_r <= WDATA_I[15:0];
            if (wr_period) period_r <= WDATA_I;
            if (wr_trig_a) trig_a_r <= WDATA_I;
            if (wr_trig_b) trig_b_r <= WDATA_I;
            if (wr_use_set) use_set_r <= WDATA_I;
            if (wr_mask) mask_r <= WDATA_I[iac_pkg::NAL-1:0];
            if (wr_delay) delay_r[delay_idx] <= WDATA_I;
        end
    end

    // ------------------------------------------------------------
    // input sync, tick, counter and meter
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            din_m_r <= 1'b0;
            din_s_r <= 1'b0;
            din_prev_r <= 1'b0;
            tick_cnt_r <= '0;
            acc_r <= '0;
            last_r <= '0;
            win_r <= '0;
            usage_r <= '0;
        end else begin
            din_m_r <= DIN_I;
            din_s_r <= din_m_r;
            din_prev_r <= din_s_r;
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            if (clr_cnt) begin
                acc_r <= '0;
                last_r <= '0;
                win_r <= '0;
            end else if (win_end) begin
                last_r <= acc_inc;
                acc_r <= '0;
                win_r <= '0;
            end else begin
                acc_r <= acc_inc;
                if (per_mode && tick) win_r <= win_r + 32'h1;
            end
            if (clr_use) begin
                usage_r <= '0;
            end else if (tick && metering && usage_r != 32'hffff_ffff) begin
                usage_r <= usage_r + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // hold-off machines
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < iac_pkg::NAL; i++) begin
                hold_st_r[i] <= iac_pkg::IAC_ARMED;
                hold_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < iac_pkg::NAL; i++) begin
                case (hold_st_r[i])
                    iac_pkg::IAC_ARMED: begin
                        if (fire[i]) begin
                            hold_st_r[i] <= iac_pkg::IAC_HOLD;
                            hold_cnt_r[i] <= '0;
                        end
                    end
                    iac_pkg::IAC_HOLD: begin
                        if (cond[i]) begin
                            hold_cnt_r[i] <= '0;
                        end else if (tick) begin
                            if (hold_cnt_r[i] + 32'h1 >= delay_r[i]) begin
                                hold_st_r[i] <= iac_pkg::IAC_ARMED;
                            end
                            hold_cnt_r[i] <= hold_cnt_r[i] + 32'h1;
                        end
                    end
                    default: begin
                        hold_st_r[i] <= iac_pkg::IAC_ARMED;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // requests, status, read data
    // ------------------------------------------------------------
    wire logic [iac_pkg::NAL-1:0] sts_clr = wr_sts ? WDATA_I[iac_pkg::NAL-1:0] : '0;
    logic [iac_pkg::NAL-1:0] live_hold;
    always_comb begin
        for (int i = 0; i < iac_pkg::NAL; i++) begin
            live_hold[i] = (hold_st_r[i] == iac_pkg::IAC_HOLD);
        end
    end
    logic [31:0] rd_mux;
    always_comb begin
        case (ADDR_I)
            iac_pkg::OFS_CTRL: rd_mux = {25'h0, ctrl_r};
            iac_pkg::OFS_NOTE_EN: rd_mux = {28'h0, note_en_r};
            iac_pkg::OFS_SVC_EN: rd_mux = {29'h0, svc_en_r};
            iac_pkg::OFS_SCALE: rd_mux = {16'h0, scale_r};
            iac_pkg::OFS_PERIOD: rd_mux = period_r;
            iac_pkg::OFS_TRIG_A: rd_mux = trig_a_r;
            iac_pkg::OFS_TRIG_B: rd_mux = trig_b_r;
            iac_pkg::OFS_USE_SET: rd_mux = use_set_r;
            iac_pkg::OFS_COUNT: rd_mux = count_view;
            iac_pkg::OFS_USAGE: rd_mux = usage_r;
            iac_pkg::OFS_STATUS: rd_mux = {28'h0, sts_r};
            iac_pkg::OFS_MASK: rd_mux = {28'h0, mask_r};
            iac_pkg::OFS_LIVE: rd_mux = {23'h0, din_mon, live_hold, cond};
            default: begin
                if (ADDR_I[iac_pkg::AW-1:4] == iac_pkg::OFS_DELAY0[iac_pkg::AW-1:4]) begin
                    rd_mux = delay_r[delay_idx];
                end else begin
                    rd_mux = 32'h0;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            sts_r <= '0;
            req_r <= '0;
            rdata_r <= '0;
        end else begin
            sts_r <= (sts_r & ~sts_clr) | fire;
            req_r.note <= fire & note_en_r;
            req_r.svc <= fire[iac_pkg::NAL-1:1] & svc_en_r;
            rdata_r <= RD_I ? rd_mux : 32'h0;
        end
    end

    assign REQ_O = req_r;
    assign RDATA_O = rdata_r;
    assign IRQ_O = |(sts_r & mask_r);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_state_fire;
        fire[iac_pkg::AL_STATE] && note_en_r[iac_pkg::AL_STATE];
    endsequence
    property p_state_note;
        s_state_fire |=> REQ_O.note[iac_pkg::AL_STATE] ##1 !REQ_O.note[iac_pkg::AL_STATE];
    endproperty
    a_state_note: assert property (p_state_note) else $error("state notice missing");

    property p_note_gate;
        REQ_O.note[iac_pkg::AL_STATE] |-> $past(note_en_r[iac_pkg::AL_STATE]);
    endproperty
    a_note_gate: assert property (p_note_gate) else $error("notice without enable");

    property p_state_alarm_rearm_delay;
        fire[iac_pkg::AL_STATE] |=> !fire[iac_pkg::AL_STATE] [*2];
    endproperty
    a_state_alarm_rearm_delay: assert property (p_state_alarm_rearm_delay) else $error("state rearmed early");

    property p_polarity;
        fire[iac_pkg::AL_STATE] |-> (din_s_r != ctrl_r.alarm_polarity_inv);
    endproperty
    a_polarity: assert property (p_polarity) else $error("state alarm wrong polarity");

    property p_edge_count;
        (cnt_inc && !per_mode && !wr_cmd) |=> acc_r == $past(acc_r) + 32'h1;
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("edge not counted");

    property p_raw_view;
        (scale_r == 16'h0000) |-> (count_view == raw_view);
    endproperty
    a_raw_view: assert property (p_raw_view) else $error("unscaled view wrong");

    property p_window;
        (win_end && !wr_cmd) |=> (last_r == $past(acc_inc)) && (acc_r == 32'h0);
    endproperty
    a_window: assert property (p_window) else $error("period total wrong");

    property p_cnt_svc;
        (fire[iac_pkg::AL_CNT_A] && svc_en_r[0]) |=> REQ_O.svc[0];
    endproperty
    a_cnt_svc: assert property (p_cnt_svc) else $error("count service missing");

    property p_usage_acc;
        (tick && metering && !wr_cmd && usage_r != 32'hffff_ffff) |=>
            usage_r == $past(usage_r) + 32'h1;
    endproperty
    a_usage_acc: assert property (p_usage_acc) else $error("usage not accrued");

    property p_usage_en;
        fire[iac_pkg::AL_USAGE] |-> ctrl_r.usage_alarm_en && (usage_r >= use_set_r);
    endproperty
    a_usage_en: assert property (p_usage_en) else $error("usage alarm unqualified");

    property p_irq;
        (fire[iac_pkg::AL_CNT_A] && mask_r[iac_pkg::AL_CNT_A] && !wr_mask) |=> IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_cnt_note;
        (fire[iac_pkg::AL_CNT_B] && note_en_r[iac_pkg::AL_CNT_B]) |=>
            REQ_O.note[iac_pkg::AL_CNT_B];
    endproperty
    a_cnt_note: assert property (p_cnt_note) else $error("count b notice missing");

    property p_svc_gate;
        REQ_O.svc[iac_pkg::AL_CNT_A-1] |-> $past(svc_en_r[iac_pkg::AL_CNT_A-1]);
    endproperty
    a_svc_gate: assert property (p_svc_gate) else $error("service without enable");

    property p_use_svc;
        (fire[iac_pkg::AL_USAGE] && svc_en_r[iac_pkg::AL_USAGE-1]) |=>
            REQ_O.svc[iac_pkg::AL_USAGE-1];
    endproperty
    a_use_svc: assert property (p_use_svc) else $error("usage service missing");

    property p_use_gate;
        REQ_O.note[iac_pkg::AL_USAGE] |-> $past(note_en_r[iac_pkg::AL_USAGE]);
    endproperty
    a_use_gate: assert property (p_use_gate) else $error("usage notice ungated");

    sequence s_cnt_held;
        (hold_st_r[iac_pkg::AL_CNT_A] == iac_pkg::IAC_HOLD) && cond[iac_pkg::AL_CNT_A];
    endsequence
    property p_cnt_held;
        s_cnt_held |=> hold_st_r[iac_pkg::AL_CNT_A] == iac_pkg::IAC_HOLD;
    endproperty
    a_cnt_held: assert property (p_cnt_held) else $error("count alarm rearmed early");

    property p_use_held;
        (hold_st_r[iac_pkg::AL_USAGE] == iac_pkg::IAC_HOLD) && cond[iac_pkg::AL_USAGE] |=>
            hold_st_r[iac_pkg::AL_USAGE] == iac_pkg::IAC_HOLD;
    endproperty
    a_use_held: assert property (p_use_held) else $error("usage alarm rearmed early");
endmodule : iac_top
`default_nettype wire

//--- hw/iac_pkg.sv
// package of the input alarm, counter and usage meter block
// assumes one 10 MHz clock and a single conditioned input channel
`default_nettype none
package iac_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [31:0] REARM_DELAY_MS_DEF = 32'h000493e0;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int AW = 7;
    localparam logic [AW-1:0] OFS_CTRL = 7'h00;
    localparam logic [AW-1:0] OFS_NOTE_EN = 7'h04;
    localparam logic [AW-1:0] OFS_SVC_EN = 7'h08;
    localparam logic [AW-1:0] OFS_SCALE = 7'h0c;
    localparam logic [AW-1:0] OFS_PERIOD = 7'h10;
    localparam logic [AW-1:0] OFS_TRIG_A = 7'h14;
    localparam logic [AW-1:0] OFS_TRIG_B = 7'h18;
    localparam logic [AW-1:0] OFS_USE_SET = 7'h1c;
    localparam logic [AW-1:0] OFS_DELAY0 = 7'h20;
    localparam logic [AW-1:0] OFS_COUNT = 7'h30;
    localparam logic [AW-1:0] OFS_USAGE = 7'h34;
    localparam logic [AW-1:0] OFS_STATUS = 7'h38;
    localparam logic [AW-1:0] OFS_MASK = 7'h3c;
    localparam logic [AW-1:0] OFS_CMD = 7'h40;
    localparam logic [AW-1:0] OFS_LIVE = 7'h44;
    // ------------------------------------------------------------
    // alarm indices and fields
    // ------------------------------------------------------------
    localparam int NAL = 4;
    localparam int AL_STATE = 0;
    localparam int AL_CNT_A = 1;
    localparam int AL_CNT_B = 2;
    localparam int AL_USAGE = 3;
    localparam int CMD_CLR_CNT = 0;
    localparam int CMD_CLR_USE = 1;
    localparam int SCALE_FRAC = 8;
    localparam logic [6:0] CTRL_RST = 7'h0c;
    typedef struct packed {
        logic usage_alarm_en;
        logic cnt_b_en;
        logic cnt_a_en;
        logic metered_state_select;
        logic count_edge_select;
        logic alarm_polarity_inv;
        logic state_alarm_en;
    } iac_ctrl_t;
    typedef struct packed {
        logic [NAL-1:0] note;
        logic [NAL-2:0] svc;
    } iac_req_t;
    typedef enum logic {IAC_ARMED, IAC_HOLD} iac_hold_t;
endpackage : iac_pkg
`default_nettype wire

//--- sim/iac_contact_model.sv
// contact model: a field contact or pulse sensor on the conditioned input
// assumes the bench calls its tasks from one process, after a rising edge
`default_nettype none
module iac_contact_model (
    // clock
    input wire logic clk_i,
    // contact level
    output logic din_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial din_o = 1'b0;
    // full pulses, five cycles on and five off
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            din_o <= 1'b1;
            repeat (5) @(posedge clk_i);
            din_o <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
    endtask : pulses
    // new level, held long enough for the synchroniser
    task automatic set_level(input logic v);
        @(posedge clk_i);
        din_o <= v;
        repeat (8) @(posedge clk_i);
    endtask : set_level
endmodule : iac_contact_model
`default_nettype wire

//--- sim/tb_top.sv
// testbench of the input alarm, counter and usage meter
// assumes a 1 ms tick shortened to 10 cycles and small hold-off delays for the state and count a alarms
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rstn;
    logic din;
    logic [iac_pkg::AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    iac_pkg::iac_req_t req;
    logic irq;
    int bad_count = 0;
    int total_checks = 0;
    int note_seen [4];
    int svc_seen [3];

    always #50 mclk = ~mclk;

    iac_contact_model u_contact (.clk_i(mclk), .din_o(din));

    iac_top #(.MS_TICK_CYC(10)) dut (
        .MCLK_I(mclk), .RSTN_I(rstn), .DIN_I(din), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .REQ_O(req), .IRQ_O(irq)
    );

    // ------------------------------------------------------------
    // request pulse counters
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (req.note[i] === 1'b1)
                note_seen[i]++;
        end
        for (int i = 0; i < 3; i++) begin
            if (req.svc[i] === 1'b1)
                svc_seen[i]++;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [iac_pkg::AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [iac_pkg::AW-1:0] a,
                          input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(what, rdata, exp);
    endtask : rd_chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rstn <= 1'b0;
        addr <= '0;
        wdata <= '0;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        // reset values
        rd_chk("ctrl", iac_pkg::OFS_CTRL, 32'h0000000c);
        for (int i = 0; i < 4; i++) begin
            rd_chk("delay", iac_pkg::OFS_DELAY0 + 7'(4 * i), 32'h000493e0);
        end
        rd_chk("note_en", iac_pkg::OFS_NOTE_EN, 32'h0);
        rd_chk("svc_en", iac_pkg::OFS_SVC_EN, 32'h0);
        rd_chk("trig_a", iac_pkg::OFS_TRIG_A, 32'h0);
        rd_chk("trig_b", iac_pkg::OFS_TRIG_B, 32'h0);
        rd_chk("scale", iac_pkg::OFS_SCALE, 32'h0);
        rd_chk("period", iac_pkg::OFS_PERIOD, 32'h0);
        rd_chk("use_set", iac_pkg::OFS_USE_SET, 32'h0);
        rd_chk("unmapped", 7'h7c, 32'h0);
        // count alarms a and b on the scaled count
        wr_reg(iac_pkg::OFS_TRIG_A, 32'h00000004);
        wr_reg(iac_pkg::OFS_TRIG_B, 32'h00000005);
        wr_reg(iac_pkg::OFS_SCALE, 32'h00000200);
        wr_reg(iac_pkg::OFS_SVC_EN, 32'h00000003);
        wr_reg(iac_pkg::OFS_NOTE_EN, 32'h00000006);
        wr_reg(iac_pkg::OFS_MASK, 32'h00000002);
        wr_reg(iac_pkg::OFS_DELAY0 + 7'h04, 32'h00000014);
        wr_reg(iac_pkg::OFS_CTRL, 32'h0000003c);
        u_contact.pulses(2);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h00000004);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h0);
        u_contact.pulses(1);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h00000006);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h00000006);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("svc_a", 32'(svc_seen[0]), 32'h1);
        chk("svc_b", 32'(svc_seen[1]), 32'h1);
        chk("note_a", 32'(note_seen[1]), 32'h1);
        chk("note_b", 32'(note_seen[2]), 32'h1);
        wr_reg(iac_pkg::OFS_MASK, 32'h0);
        @(negedge mclk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr_reg(iac_pkg::OFS_STATUS, 32'h00000006);
        wr_reg(iac_pkg::OFS_SVC_EN, 32'h0);
        wr_reg(iac_pkg::OFS_CMD, 32'h00000001);
        u_contact.pulses(3);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h0);
        wr_reg(iac_pkg::OFS_CMD, 32'h00000001);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h0);
        repeat (260) @(posedge mclk);
        u_contact.pulses(3);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h00000002);
        chk("note_a", 32'(note_seen[1]), 32'h2);
        chk("note_b", 32'(note_seen[2]), 32'h1);
        chk("svc_a", 32'(svc_seen[0]), 32'h1);
        // falling edge counting, then sampling period
        wr_reg(iac_pkg::OFS_CTRL, 32'h00000008);
        wr_reg(iac_pkg::OFS_SCALE, 32'h0);
        wr_reg(iac_pkg::OFS_CMD, 32'h00000001);
        u_contact.set_level(1'b1);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h0);
        u_contact.set_level(1'b0);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h00000001);
        wr_reg(iac_pkg::OFS_PERIOD, 32'h0000000a);
        u_contact.pulses(3);
        repeat (100) @(posedge mclk);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h00000004);
        repeat (150) @(posedge mclk);
        rd_chk("count", iac_pkg::OFS_COUNT, 32'h0);
        wr_reg(iac_pkg::OFS_PERIOD, 32'h0);
        // state alarm, polarity and hold-off
        wr_reg(iac_pkg::OFS_STATUS, 32'h0000000f);
        wr_reg(iac_pkg::OFS_DELAY0, 32'h00000002);
        wr_reg(iac_pkg::OFS_NOTE_EN, 32'h0);
        wr_reg(iac_pkg::OFS_CTRL, 32'h0000000d);
        u_contact.set_level(1'b1);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h00000001);
        chk("note_st", 32'(note_seen[0]), 32'h0);
        u_contact.set_level(1'b0);
        repeat (40) @(posedge mclk);
        wr_reg(iac_pkg::OFS_STATUS, 32'h00000001);
        wr_reg(iac_pkg::OFS_NOTE_EN, 32'h00000001);
        wr_reg(iac_pkg::OFS_CTRL, 32'h0000000f);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h00000001);
        chk("note_st", 32'(note_seen[0]), 32'h1);
        wr_reg(iac_pkg::OFS_STATUS, 32'h00000001);
        u_contact.set_level(1'b1);
        u_contact.set_level(1'b0);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h0);
        // usage meter and its alarm
        wr_reg(iac_pkg::OFS_CTRL, 32'h0000000c);
        wr_reg(iac_pkg::OFS_STATUS, 32'h0000000f);
        wr_reg(iac_pkg::OFS_USE_SET, 32'h00000005);
        wr_reg(iac_pkg::OFS_SVC_EN, 32'h00000004);
        wr_reg(iac_pkg::OFS_NOTE_EN, 32'h00000008);
        wr_reg(iac_pkg::OFS_CMD, 32'h00000002);
        u_contact.set_level(1'b1);
        repeat (100) @(posedge mclk);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h0);
        wr_reg(iac_pkg::OFS_CTRL, 32'h0000004c);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h00000008);
        chk("svc_use", 32'(svc_seen[2]), 32'h1);
        chk("note_use", 32'(note_seen[3]), 32'h1);
        wr_reg(iac_pkg::OFS_STATUS, 32'h00000008);
        wr_reg(iac_pkg::OFS_CMD, 32'h00000002);
        repeat (100) @(posedge mclk);
        rd_chk("status", iac_pkg::OFS_STATUS, 32'h0);
        wr_reg(iac_pkg::OFS_CTRL, 32'h00000044);
        wr_reg(iac_pkg::OFS_CMD, 32'h00000002);
        repeat (60) @(posedge mclk);
        rd_chk("usage", iac_pkg::OFS_USAGE, 32'h0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
